// file: rtl/rfc_converter.sv
/*
 One channel of the resistance-to-frequency converter control: AXI4-Lite
 registers, measurement and time-base counters, sequencing and drives.
 Assumes the analog oscillator, clock sources and pins sit outside and
 arrive asynchronous to clk_i.
*/
// Functional notes
// - Clock source and divide fields set clock
// - Time-base counts only divided operating clock
// - Debug without run bit stops clock
// - Frozen converter holds pins and registers
// - Run bit keeps clock during debug
// - Writing one clears a flag
// - Mode field picks DC or AC
// - DC mode drives two sensors
// - AC mode drives only sensor A
// - External input replaces oscillation clock
// - Channel keeps its own mode settings
// - Presettable 24-bit measurement up counter
// - Presettable 24-bit up/down time-base counter
// - Reference phase counts time-base up
// - Sensor phase counts down, stops at zero
// - Saved time-base preset is accepted
// - Measurement overflow cancels sensor phase
// - Reference overflow stops with flag
// - Sensor zero stops with done flag
// - Writing zero aborts, counters held
// - DC-only channel ignores AC mode
`timescale 1ns/10ps
`include "rfc_defines.svh"
module rfc_converter #(
    parameter int CNT_W = 24,
    parameter bit DC_ONLY = 1'b0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic debug_mode_i,
    input wire logic [3:0] op_clock_sources_i,
    input wire logic cr_oscillation_clock_i,
    input wire logic oscillation_input_pin_i,
    output logic reference_drive_pin_oe_o,
    output logic sensor_a_drive_pin_oe_o,
    output logic sensor_b_drive_pin_oe_o,
    output logic ac_drive_o,
    output logic oscillation_monitor_output_o
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [5:0] async_in = {oscillation_input_pin_i, cr_oscillation_clock_i,
                           op_clock_sources_i};
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    rfc_pkg::rfc_clk_s clk_q;
    rfc_pkg::rfc_ctl_s ctl_q;
    rfc_pkg::rfc_state_e state_q;
    rfc_pkg::rfc_state_e state_d;
    rfc_pkg::rfc_flags_t flags_q;
    rfc_pkg::rfc_flags_t flags_d;
    logic [CNT_W-1:0] mc_q;
    logic [CNT_W-1:0] mc_d;
    logic [CNT_W-1:0] tc_q;
    logic [CNT_W-1:0] tc_d;
    logic op_prev_q;
    logic osc_prev_q;

    // ----------------------------------------
    // Clock selection and gating
    // ----------------------------------------
    // source then divider
    wire op_lvl = sync2_q[clk_q.operating_clock_source_select];
    wire op_edge = op_lvl & ~op_prev_q;
    wire osc_lvl = ctl_q.external_clock_input_enable ? sync2_q[5] : sync2_q[4];
    wire osc_edge = osc_lvl & ~osc_prev_q;
    // gate in debug, run bit overrides
    wire freeze = debug_mode_i & ~clk_q.run_in_debug;
    wire tc_tick;

    rfc_tick_div u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .edge_i(op_edge),
        .run_i(~freeze),
        .div_sel_i(clk_q.operating_clock_divide_select),
        .tick_o(tc_tick)
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire aw_hs = s_axi_awvalid_i & awready_q;
    wire w_hs = s_axi_wvalid_i & wready_q;
    wire ar_hs = s_axi_arvalid_i & arready_q;
    wire wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire wr_clk = wr_fire & (waddr_q == `RFC_OFS_CLK);
    wire wr_ctl = wr_fire & (waddr_q == `RFC_OFS_CTL);
    wire wr_trg = wr_fire & (waddr_q == `RFC_OFS_TRG);
    wire wr_mc = wr_fire & (waddr_q == `RFC_OFS_MC);
    wire wr_tc = wr_fire & (waddr_q == `RFC_OFS_TC);
    wire wr_intf = wr_fire & (waddr_q == `RFC_OFS_INTF);
    wire w_map = wr_clk | wr_ctl | wr_trg | wr_mc | wr_tc | wr_intf;

    wire [31:0] clk_rd = 32'(clk_q.operating_clock_source_select)
        << `RFC_CLK_SRC_LSB
        | 32'(clk_q.operating_clock_divide_select) << `RFC_CLK_DIV_LSB
        | 32'(clk_q.run_in_debug) << `RFC_CLK_RUN_IN_DEBUG_BIT;
    wire [31:0] ctl_rd = 32'(ctl_q.converter_enable) << `RFC_CTL_EN_BIT
        | 32'(ctl_q.external_clock_input_enable) << `RFC_CTL_EXT_BIT
        | 32'(ctl_q.oscillation_mode_select) << `RFC_CTL_MODE_LSB;
    wire [31:0] trg_rd = 32'(state_q == rfc_pkg::ST_REF) << `RFC_TRG_REF_BIT
        | 32'(state_q == rfc_pkg::ST_SENA) << `RFC_TRG_SENA_BIT
        | 32'(state_q == rfc_pkg::ST_SENB) << `RFC_TRG_SENB_BIT;
    wire [31:0] clk_wr = (clk_rd & ~wmask) | (wdata_q & wmask);
    wire [31:0] ctl_wr = (ctl_rd & ~wmask) | (wdata_q & wmask);
    wire [31:0] trg_wr = (trg_rd & ~wmask) | (wdata_q & wmask);
    wire [31:0] mc_wr = (32'(mc_q) & ~wmask) | (wdata_q & wmask);
    wire [31:0] tc_wr = (32'(tc_q) & ~wmask) | (wdata_q & wmask);
    wire [4:0] clr = wr_intf ? 5'(wdata_q & wmask) : 5'h00;

    wire [7:0] ra = s_axi_araddr_i;
    wire r_map = (ra == `RFC_OFS_CLK) | (ra == `RFC_OFS_CTL)
        | (ra == `RFC_OFS_TRG) | (ra == `RFC_OFS_MC)
        | (ra == `RFC_OFS_TC) | (ra == `RFC_OFS_INTF);
    wire [31:0] rd_mux = (ra == `RFC_OFS_CLK) ? clk_rd
        : (ra == `RFC_OFS_CTL) ? ctl_rd
        : (ra == `RFC_OFS_TRG) ? trg_rd
        : (ra == `RFC_OFS_MC) ? 32'(mc_q)
        : (ra == `RFC_OFS_TC) ? 32'(tc_q)
        : (ra == `RFC_OFS_INTF) ? 32'(flags_q) : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RFC_RESP_OKAY;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                waddr_q <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_map ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RFC_RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= r_map ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // DC-only channel, mode field, other codes act as DC
    wire ac_mode = ~DC_ONLY
        & (ctl_q.oscillation_mode_select == `RFC_MODE_AC);
    wire is_ref = state_q == rfc_pkg::ST_REF;
    wire is_sens = (state_q == rfc_pkg::ST_SENA)
        | (state_q == rfc_pkg::ST_SENB);
    wire active = is_ref | is_sens;
    wire mc_inc = active & osc_edge & ~freeze;
    wire mc_wrap = mc_inc & (&mc_q);
    wire tc_wrap = is_ref & tc_tick & (&tc_q);
    // zero reached or preset already zero
    wire tc_zero = is_sens & ~freeze
        & ((tc_q == '0) | (tc_tick & (tc_q == CNT_W'(1))));
    // abort when the running start bit is written zero
    wire abort = wr_trg & ((is_ref & ~trg_wr[`RFC_TRG_REF_BIT])
        | ((state_q == rfc_pkg::ST_SENA) & ~trg_wr[`RFC_TRG_SENA_BIT])
        | ((state_q == rfc_pkg::ST_SENB) & ~trg_wr[`RFC_TRG_SENB_BIT]));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rfc_pkg::ST_IDLE: begin
                // start takes effect at the next clk_i edge
                if (wr_trg && ctl_q.converter_enable) begin
                    if (trg_wr[`RFC_TRG_REF_BIT]) begin
                        state_d = rfc_pkg::ST_REF;
                    end else if (trg_wr[`RFC_TRG_SENA_BIT]) begin
                        state_d = rfc_pkg::ST_SENA;
                    // sensor B refused in AC mode
                    end else if (trg_wr[`RFC_TRG_SENB_BIT] && !ac_mode) begin
                        state_d = rfc_pkg::ST_SENB;
                    end
                end
            end
            rfc_pkg::ST_REF: begin
                if (abort || mc_wrap || tc_wrap) begin
                    state_d = rfc_pkg::ST_IDLE;
                end
            end
            rfc_pkg::ST_SENA, rfc_pkg::ST_SENB: begin
                if (abort || mc_wrap || tc_zero) begin
                    state_d = rfc_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // flag sources; overflow wins over zero
    wire [4:0] set = {tc_wrap, is_sens & mc_wrap,
        (state_q == rfc_pkg::ST_SENB) & tc_zero & ~mc_wrap,
        (state_q == rfc_pkg::ST_SENA) & tc_zero & ~mc_wrap,
        is_ref & mc_wrap};
    // write one clears, a same-cycle set wins
    assign flags_d = (flags_q & ~clr) | set;

    assign mc_d = wr_mc ? mc_wr[CNT_W-1:0] : (mc_inc ? mc_q + 1'b1 : mc_q);
    // time-base moves only on the divided tick
    assign tc_d = wr_tc ? tc_wr[CNT_W-1:0]
        : (is_ref & tc_tick) ? tc_q + 1'b1
        : (is_sens & tc_tick & (tc_q != '0)) ? tc_q - 1'b1 : tc_q;

    // freeze holds state, counters and pins
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= rfc_pkg::ST_IDLE;
            flags_q <= 5'h00;
            mc_q <= `RFC_CNT_RST;
            tc_q <= `RFC_CNT_RST;
        end else begin
            state_q <= freeze ? state_q : state_d;
            flags_q <= flags_d;
            mc_q <= mc_d;
            tc_q <= tc_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            clk_q <= 5'(`RFC_CLK_RST);
            ctl_q <= 4'(`RFC_CTL_RST);
            op_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            op_prev_q <= op_lvl;
            osc_prev_q <= osc_lvl;
            if (wr_clk) begin
                clk_q.operating_clock_source_select <= clk_wr[1:0];
                clk_q.operating_clock_divide_select <= clk_wr[5:4];
                clk_q.run_in_debug <= clk_wr[`RFC_CLK_RUN_IN_DEBUG_BIT];
            end
            if (wr_ctl) begin
                ctl_q.converter_enable <= ctl_wr[`RFC_CTL_EN_BIT];
                ctl_q.external_clock_input_enable <= ctl_wr[`RFC_CTL_EXT_BIT];
                ctl_q.oscillation_mode_select <= ctl_wr[5:4];
            end
        end
    end

    // ----------------------------------------
    // Pin drives
    // ----------------------------------------
    logic ref_oe_q;
    logic sena_oe_q;
    logic senb_oe_q;
    logic ac_q;
    logic mon_q;

    // drive enables follow the phase; frozen state holds them
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_oe_q <= 1'b0;
            sena_oe_q <= 1'b0;
            senb_oe_q <= 1'b0;
            ac_q <= 1'b0;
            mon_q <= 1'b0;
        end else if (!freeze) begin
            ref_oe_q <= state_d == rfc_pkg::ST_REF;
            sena_oe_q <= state_d == rfc_pkg::ST_SENA;
            senb_oe_q <= state_d == rfc_pkg::ST_SENB;
            ac_q <= ac_mode;
            mon_q <= active & osc_lvl;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign reference_drive_pin_oe_o = ref_oe_q;
    assign sensor_a_drive_pin_oe_o = sena_oe_q;
    assign sensor_b_drive_pin_oe_o = senb_oe_q;
    assign ac_drive_o = ac_q;
    assign oscillation_monitor_output_o = mon_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ref_done_stop: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        is_ref && mc_wrap && !freeze |=> state_q == rfc_pkg::ST_IDLE && flags_q[0]
    ) else $error("reference overflow did not finish");

    a_tc_ovf_flag: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        tc_wrap && !wr_tc |=> flags_q[4] && tc_q == '0
    ) else $error("time-base overflow not flagged");

    a_sens_zero_done: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state_q == rfc_pkg::ST_SENA && tc_zero && !mc_wrap
        |=> flags_q[1] && state_q == rfc_pkg::ST_IDLE
    ) else $error("sensor A zero not completed");

    a_sens_mc_cancel: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        is_sens && mc_wrap |-> set[2:1] == 2'h0
            ##1 (flags_q[3] && state_q == rfc_pkg::ST_IDLE)
    ) else $error("sensor overflow not cancelled");

    a_freeze_hold: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        freeze && !wr_mc && !wr_tc |=> $stable(mc_q) && $stable(tc_q)
            && $stable(state_q) && $stable(reference_drive_pin_oe_o)
    ) else $error("frozen converter changed");

    a_tc_tick_only: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !wr_tc && !tc_tick |=> $stable(tc_q)
    ) else $error("time-base moved without tick");

    a_flag_set_wins: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        set[0] && clr[0] |=> flags_q[0]
    ) else $error("clear beat a set");

    a_ac_no_b: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state_q == rfc_pkg::ST_IDLE && wr_trg && ac_mode
            && trg_wr[2:0] == 3'h4 |=> state_q == rfc_pkg::ST_IDLE
    ) else $error("sensor B started in AC mode");

    a_ext_count: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        active && !freeze && ctl_q.external_clock_input_enable
            && sync2_q[5] && !osc_prev_q && !wr_mc
        |=> mc_q == $past(mc_q) + 1'b1
    ) else $error("external edge not counted");

    a_abort_idle: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        abort && !freeze |=> state_q == rfc_pkg::ST_IDLE
    ) else $error("abort did not stop");

endmodule

// file: rtl/rfc_defines.svh
/*
 Register offsets, field positions, reset values and codes of the
 converter channel. Assumes byte addresses on a 32-bit AXI4-Lite bus.
*/
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RFC_OFS_CLK 8'h00
`define RFC_OFS_CTL 8'h04
`define RFC_OFS_TRG 8'h08
`define RFC_OFS_MC 8'h0c
`define RFC_OFS_TC 8'h10
`define RFC_OFS_INTF 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFC_CLK_SRC_LSB 0
`define RFC_CLK_DIV_LSB 4
`define RFC_CLK_RUN_IN_DEBUG_BIT 8
`define RFC_CTL_EN_BIT 0
`define RFC_CTL_EXT_BIT 1
`define RFC_CTL_MODE_LSB 4
`define RFC_TRG_REF_BIT 0
`define RFC_TRG_SENA_BIT 1
`define RFC_TRG_SENB_BIT 2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RFC_CLK_RST 32'h0000_0000
`define RFC_CTL_RST 32'h0000_0000
`define RFC_CNT_RST 24'h00_0000
`define RFC_MODE_DC 2'h0
`define RFC_MODE_AC 2'h1
`define RFC_RESP_OKAY 2'h0
`define RFC_RESP_SLVERR 2'h2

`endif

// file: rtl/rfc_pkg.sv
/*
 Types shared by the converter channel files.
 Assumes the constants of rfc_defines.svh for field positions.
*/
package rfc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REF,
        ST_SENA,
        ST_SENB
    } rfc_state_e;

    typedef struct packed {
        logic run_in_debug;
        logic [1:0] operating_clock_divide_select;
        logic [1:0] operating_clock_source_select;
    } rfc_clk_s;

    typedef struct packed {
        logic [1:0] oscillation_mode_select;
        logic external_clock_input_enable;
        logic converter_enable;
    } rfc_ctl_s;

    // Order: time-base overflow, meas overflow, sensor B, sensor A, ref
    typedef logic [4:0] rfc_flags_t;

endpackage

// file: rtl/rfc_tick_div.sv
/*
 Divider of the time-base operating clock: one tick out per 1, 2, 4
 or 8 selected source edges. Assumes edges arrive as one-cycle pulses
 already synchronised to clk_i.
*/
`timescale 1ns/10ps
module rfc_tick_div (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic edge_i,
    input wire logic run_i,
    input wire logic [1:0] div_sel_i,
    output logic tick_o
);

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    wire [2:0] limit = 3'((4'h1 << div_sel_i) - 4'h1);
    wire step = edge_i & run_i;
    wire at_limit = cnt_q >= limit;

    assign cnt_d = !step ? cnt_q : (at_limit ? 3'h0 : cnt_q + 3'h1);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Combinational so the tick lines up with the source edge
    assign tick_o = step & at_limit;

endmodule

// file: verification/rfc_sensor_model.sv
/*
 Far-side model: CR oscillator, clock generator sources, external pulses.
 Assumes drive enables from the converter and a pulse enable from the bench.
*/
`timescale 1ns/10ps
module rfc_sensor_model (
    input wire logic ref_oe_i,
    input wire logic sena_oe_i,
    input wire logic senb_oe_i,
    input wire logic pulse_en_i,
    output logic osc_o,
    output logic pin_o,
    output logic [3:0] src_o
);
    initial begin
        osc_o = 1'b0;
        pin_o = 1'b0;
        src_o = 4'h0;
    end
    // Stands still unless a resistor is driven
    always #100 osc_o = (ref_oe_i | sena_oe_i | senb_oe_i) ? ~osc_o : 1'b0;
    always #130 pin_o = pulse_en_i ? ~pin_o : 1'b0;
    always #60 src_o[0] = ~src_o[0];
    always #90 src_o[1] = ~src_o[1];
    always #210 src_o[2] = ~src_o[2];
    always #50 src_o[3] = ~src_o[3];
endmodule

// file: verification/cr_oscillation_resistance_converter_bench.sv
/*
 Bench of a converter channel and a DC-only channel: AXI4-Lite tasks and measurement runs.
 Assumes the far-side model drives oscillator, sources and pulse pin.
*/
`timescale 1ns/10ps
`include "rfc_defines.svh"
module cr_oscillation_resistance_converter_bench;
    logic clk_i = 1'b0, resetn_i = 1'b0, dbg = 1'b0, pulse_en = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, save;
    logic awready, wready, bvalid, arready, rvalid, osc, pin, ref_oe, sena_oe, senb_oe, ac;
    logic ac1, mon, mon_seen = 1'b0;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] src;
    int fail_count = 0, cmp_count = 0, cyc = 0;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (mon === 1'b1) mon_seen <= 1'b1;

    rfc_converter DUT (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .debug_mode_i(dbg), .op_clock_sources_i(src),
        .cr_oscillation_clock_i(osc), .oscillation_input_pin_i(pin),
        .reference_drive_pin_oe_o(ref_oe), .sensor_a_drive_pin_oe_o(sena_oe),
        .sensor_b_drive_pin_oe_o(senb_oe), .ac_drive_o(ac),
        .oscillation_monitor_output_o(mon));

    // Channel variant that only offers DC sensor oscillation
    rfc_converter #(.DC_ONLY(1'b1)) DUT_DC (.clk_i(clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(),
        .s_axi_rdata_o(), .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rready),
        .debug_mode_i(dbg), .op_clock_sources_i(src), .cr_oscillation_clock_i(osc),
        .oscillation_input_pin_i(pin), .reference_drive_pin_oe_o(),
        .sensor_a_drive_pin_oe_o(), .sensor_b_drive_pin_oe_o(), .ac_drive_o(ac1),
        .oscillation_monitor_output_o());

    rfc_sensor_model FAR (.ref_oe_i(ref_oe), .sena_oe_i(sena_oe), .senb_oe_i(senb_oe),
        .pulse_en_i(pulse_en), .osc_o(osc), .pin_o(pin), .src_o(src));

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic start(input logic [2:0] trg, input logic [23:0] mc, input logic [23:0] tc);
        wr(`RFC_OFS_MC, {8'h00, mc});
        wr(`RFC_OFS_TC, {8'h00, tc});
        wr(`RFC_OFS_INTF, 32'h1f);
        wr(`RFC_OFS_TRG, {29'h0, trg});
    endtask

    // Polls the start bits; the phase clears its own bit when it ends
    task automatic wait_idle(input logic [31:0] exp_flags, input string name);
        for (int n = 0; n < 400; n++) begin
            rdr(`RFC_OFS_TRG);
            if (rd === 32'h0) break;
        end
        rdr(`RFC_OFS_INTF);
        check(name, exp_flags, rd);
    endtask

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            final_report;
        end
    end

    // ----------------------------------------
    // Measurement sequences
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdr(`RFC_OFS_CLK);
        check("clk reset", `RFC_CLK_RST, rd);
        rdr(8'h18);
        check("unmapped rresp", {30'h0, `RFC_RESP_SLVERR}, {30'h0, resp});
        wr(8'h18, 32'h1);
        check("unmapped bresp", {30'h0, `RFC_RESP_SLVERR}, {30'h0, resp});
        wr(`RFC_OFS_TRG, 32'h1);
        rdr(`RFC_OFS_TRG);
        check("start disabled", 32'h0, rd);
        check("monitor idle", 32'h0, {31'h0, mon});
        wr(`RFC_OFS_CLK, 32'h10);
        wr(`RFC_OFS_CTL, 32'h1);
        rdr(`RFC_OFS_CLK);
        check("clk fields", 32'h10, rd);
        start(3'h1, 24'hfffff0, 24'h0);
        wait_idle(32'h01, "ref done");
        rdr(`RFC_OFS_TC);
        check("tc counted up", 32'h1, {31'h0, rd != 32'h0});
        start(3'h1, 24'h0, 24'hfffffc);
        wait_idle(32'h10, "tc overflow");
        start(3'h2, 24'h0, 24'h6);
        wait_idle(32'h02, "sensor a done");
        rdr(`RFC_OFS_TC);
        check("tc at zero", 32'h0, rd);
        rdr(`RFC_OFS_MC);
        check("mc counted", 32'h1, {31'h0, rd != 32'h0});
        start(3'h4, 24'h0, 24'h3);
        wait_idle(32'h04, "sensor b done");
        start(3'h2, 24'hfffffa, 24'hffff);
        wait_idle(32'h08, "mc overflow");
        wr(`RFC_OFS_INTF, 32'h1f);
        rdr(`RFC_OFS_INTF);
        check("flags cleared", 32'h0, rd);
        start(3'h1, 24'h0, 24'h0);
        repeat (100) @(posedge clk_i);
        wr(`RFC_OFS_TRG, 32'h0);
        rdr(`RFC_OFS_MC);
        save = rd;
        repeat (50) @(posedge clk_i);
        rdr(`RFC_OFS_MC);
        check("abort holds mc", save, rd);
        start(3'h1, 24'h0, 24'h0);
        repeat (50) @(posedge clk_i);
        dbg <= 1'b1;
        repeat (10) @(posedge clk_i);
        rdr(`RFC_OFS_MC);
        save = rd;
        repeat (60) @(posedge clk_i);
        rdr(`RFC_OFS_MC);
        check("debug freeze", save, rd);
        check("debug pin held", 32'h1, {31'h0, ref_oe});
        wr(`RFC_OFS_CLK, 32'h110);
        repeat (60) @(posedge clk_i);
        rdr(`RFC_OFS_MC);
        check("debug run", 32'h1, {31'h0, rd != save});
        dbg <= 1'b0;
        wr(`RFC_OFS_TRG, 32'h0);
        wr(`RFC_OFS_CTL, 32'h11);
        rdr(`RFC_OFS_TRG);
        check("ac drive", 32'h1, {31'h0, ac});
        check("dc-only ac drive", 32'h0, {31'h0, ac1});
        wr(`RFC_OFS_TRG, 32'h4);
        rdr(`RFC_OFS_TRG);
        check("ac sensor b refused", 32'h0, rd);
        start(3'h2, 24'h0, 24'h3);
        wait_idle(32'h02, "ac sensor a");
        wr(`RFC_OFS_CTL, 32'h23);
        start(3'h1, 24'hfffff8, 24'h0);
        repeat (150) @(posedge clk_i);
        rdr(`RFC_OFS_TRG);
        check("ext input waits", 32'h1, rd);
        check("mode 2 acts as dc", 32'h0, {31'h0, ac});
        pulse_en <= 1'b1;
        wait_idle(32'h01, "ext input done");
        check("monitor toggled", 32'h1, {31'h0, mon_seen});
        final_report;
    end
endmodule
